/* rtl/ftm_pkg.sv */
package ftm_pkg;
  // Core clock and derived rates
  localparam int unsigned CORE_CLK_HZ   = 10_000_000;
  localparam int unsigned INT_32K_HZ    = 32_765;
  localparam int unsigned INT_32K_DIV   = CORE_CLK_HZ / INT_32K_HZ;
  // PWM output rates, multiplier off; the duty generator steps 64 times per period
  localparam int unsigned PWM_STEPS     = 64;
  localparam int unsigned PWM_F00_HZ    = 15_625;
  localparam int unsigned PWM_F01_HZ    = 23_438;
  localparam int unsigned PWM_F10_HZ    = 40;
  localparam int unsigned PWM_F11_HZ    = 60;
  localparam int unsigned PWM_DIV00     = CORE_CLK_HZ / (PWM_STEPS * PWM_F00_HZ);
  localparam int unsigned PWM_DIV01     = CORE_CLK_HZ / (PWM_STEPS * PWM_F01_HZ);
  localparam int unsigned PWM_DIV10     = CORE_CLK_HZ / (PWM_STEPS * PWM_F10_HZ);
  localparam int unsigned PWM_DIV11     = CORE_CLK_HZ / (PWM_STEPS * PWM_F11_HZ);
  localparam int unsigned PWM_CNT_W     = 12;
  // Register offsets
  localparam logic [7:0] OFF_WAKE_STS   = 8'h50;
  localparam logic [7:0] OFF_WAKE_EN    = 8'h51;
  localparam logic [7:0] OFF_SMGT_STS   = 8'h52;
  localparam logic [7:0] OFF_SMGT_EN    = 8'h53;
  localparam logic [7:0] OFF_CLK32_CFG  = 8'h54;
  localparam logic [7:0] OFF_DUTY1      = 8'h56;
  localparam logic [7:0] OFF_DUTY2      = 8'h57;
  localparam logic [7:0] OFF_FAN_CTRL   = 8'h58;
  localparam logic [7:0] OFF_PRELOAD1   = 8'h59;
  localparam logic [7:0] OFF_PRELOAD2   = 8'h5A;
  localparam logic [7:0] OFF_COUNT1     = 8'h5B;
  localparam logic [7:0] OFF_COUNT2     = 8'h5C;
  // Fan control field positions
  localparam int unsigned FC_DIV1_LSB   = 6;
  localparam int unsigned FC_DIV2_LSB   = 4;
  localparam int unsigned FC_MUL1_BIT   = 3;
  localparam int unsigned FC_MUL2_BIT   = 2;
  localparam int unsigned FC_SRC1_BIT   = 1;
  localparam int unsigned FC_SRC2_BIT   = 0;
  // Duty register, clock config and event bit field positions
  localparam int unsigned DUTY_CSEL_BIT = 7;
  localparam int unsigned CLK32_SEL_BIT = 0;
  localparam int unsigned EVT_FAN1_BIT  = 0;
  localparam int unsigned EVT_FAN2_BIT  = 1;
  // Reset values
  localparam logic [7:0] FAN_CTRL_RST   = 8'h50;
  localparam logic [7:0] DUTY_RST       = 8'h00;
  localparam logic [7:0] PRELOAD_RST    = 8'h00;
  localparam logic [7:0] CLK32_CFG_RST  = 8'h00;
  localparam logic [1:0] EVT_RST        = 2'h0;
endpackage

/* rtl/ftm_tach_chan.sv */
`timescale 1ns/1ns
module ftm_tach_chan
  import ftm_pkg::*;
#(
  parameter int unsigned CNT_W = 8
) (
  input  wire logic             core_clk,
  input  wire logic             rst_n,
  input  wire logic             count_tick,
  input  wire logic             tach_rise,
  input  wire logic             preload_wr,
  input  wire logic [CNT_W-1:0] preload,
  input  wire logic [1:0]       div_sel,
  output logic      [CNT_W-1:0] count_q,
  output logic                  thresh_pulse_q
);
  logic [2:0] pre_q;
  logic [2:0] pre_limit;
  logic       restart;
  logic       hit;
  logic       hit_q;

  // Divisor 1, 2, 4 or 8
  assign pre_limit = 3'((4'h1 << div_sel) - 4'h1);
  assign restart   = tach_rise | preload_wr;
  assign hit       = &count_q[CNT_W-1:CNT_W-2];

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      pre_q   <= 3'h0;
      count_q <= '0;
    end else if (restart) begin
      pre_q   <= 3'h0;
      count_q <= preload;
    end else if (count_tick) begin
      if (pre_q == pre_limit) begin
        pre_q <= 3'h0;
        if (count_q != {CNT_W{1'b1}}) begin
          count_q <= count_q + 1'b1;
        end
      end else begin
        pre_q <= pre_q + 3'h1;
      end
    end
  end

  // One pulse as the count enters the top quarter
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      hit_q          <= 1'b0;
      thresh_pulse_q <= 1'b0;
    end else begin
      hit_q          <= hit;
      thresh_pulse_q <= hit & ~hit_q;
    end
  end
endmodule // ftm_tach_chan

/* rtl/ftm_pwm_tick.sv */
`timescale 1ns/1ns
module ftm_pwm_tick
  import ftm_pkg::*;
(
  input  wire logic core_clk,
  input  wire logic rst_n,
  input  wire logic src_sel,
  input  wire logic clk_sel,
  input  wire logic mult,
  output logic      step_q
);
  logic [PWM_CNT_W-1:0] cnt_q;
  logic [PWM_CNT_W-1:0] base_div;
  logic [PWM_CNT_W-1:0] limit;

  always_comb begin
    case ({src_sel, clk_sel})
      2'b00:   base_div = PWM_CNT_W'(PWM_DIV00);
      2'b01:   base_div = PWM_CNT_W'(PWM_DIV01);
      2'b10:   base_div = PWM_CNT_W'(PWM_DIV10);
      default: base_div = PWM_CNT_W'(PWM_DIV11);
    endcase
  end

  // Doubling halves the step period; odd dividers round down
  assign limit = (mult ? (base_div >> 1) : base_div) - 1'b1;

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      cnt_q  <= '0;
      step_q <= 1'b0;
    end else if (cnt_q >= limit) begin
      cnt_q  <= '0;
      step_q <= 1'b1;
    end else begin
      cnt_q  <= cnt_q + 1'b1;
      step_q <= 1'b0;
    end
  end
endmodule // ftm_pwm_tick

/* rtl/ftm_fan_tach_monitor.sv */
`timescale 1ns/1ns
module ftm_fan_tach_monitor
  import ftm_pkg::*;
#(
  parameter int unsigned CNT_W = 8
) (
  input  wire logic       core_clk,
  input  wire logic       rst_n,
  input  wire logic       tach_input_one,
  input  wire logic       tach_input_two,
  input  wire logic       ext_32k_clock_pin,
  input  wire logic [7:0] io_addr,
  input  wire logic       io_wr,
  input  wire logic       io_rd,
  input  wire logic [7:0] io_wdata,
  output logic      [7:0] io_rdata_q,
  output logic            wake_event,
  output logic            sysmgmt_event,
  output logic            fan1_pwm_step,
  output logic            fan2_pwm_step
);
  localparam int unsigned NSYNC = 3;

  logic [7:0]       fan_divisor_clock_control_q;
  logic [7:0]       duty1_q;
  logic [7:0]       duty2_q;
  logic [CNT_W-1:0] preload1_q;
  logic [CNT_W-1:0] preload2_q;
  logic [7:0]       clock32_config_reg_q;
  logic [1:0]       wake_enable_reg_1_q;
  logic [1:0]       sysmgmt_enable_reg_5_q;
  logic [1:0]       wake_sts_q;
  logic [1:0]       smgt_sts_q;
  logic [1:0]       evt_set;
  logic             clock32_present_select;

  logic [NSYNC-1:0] pin_in;
  logic [NSYNC-1:0] s1_q;
  logic [NSYNC-1:0] s2_q;
  logic [NSYNC-1:0] s3_q;
  logic [NSYNC-1:0] lvl_q;
  logic [NSYNC-1:0] rise_q;

  logic [8:0]       int32_cnt_q;
  logic             int32_tick_q;
  logic             count_tick;

  logic [CNT_W-1:0] count1;
  logic [CNT_W-1:0] count2;
  logic             thr1;
  logic             thr2;
  logic             wr_fc;
  logic             wr_pl1;
  logic             wr_pl2;
  logic             wr_duty1;
  logic             wr_duty2;
  logic             wr_clk32;
  logic             wr_wen;
  logic             wr_sen;
  logic             wr_wsts;
  logic             wr_ssts;
  logic [CNT_W-1:0] pl1_val;
  logic [CNT_W-1:0] pl2_val;
  logic [7:0]       rd_mux;

  assign pin_in = {ext_32k_clock_pin, tach_input_two, tach_input_one};

  // Three-stage synchronisers; a level is accepted once stages two and three agree
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end else begin
      s1_q <= pin_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      lvl_q  <= '0;
      rise_q <= '0;
    end else begin
      for (int i = 0; i < NSYNC; i++) begin
        rise_q[i] <= (s2_q[i] == s3_q[i]) & s3_q[i] & ~lvl_q[i];
        if (s2_q[i] == s3_q[i]) begin
          lvl_q[i] <= s3_q[i];
        end
      end
    end
  end

  // Internal 32 kHz stand-in derived from the core clock
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      int32_cnt_q  <= 9'h000;
      int32_tick_q <= 1'b0;
    end else if (int32_cnt_q == 9'(INT_32K_DIV - 1)) begin
      int32_cnt_q  <= 9'h000;
      int32_tick_q <= 1'b1;
    end else begin
      int32_cnt_q  <= int32_cnt_q + 9'h001;
      int32_tick_q <= 1'b0;
    end
  end

  // External pin only usable when software says it is fitted
  assign clock32_present_select = clock32_config_reg_q[CLK32_SEL_BIT];
  assign count_tick = clock32_present_select ? rise_q[2] : int32_tick_q;

  assign wr_fc    = io_wr & (io_addr == OFF_FAN_CTRL);
  assign wr_pl1   = io_wr & (io_addr == OFF_PRELOAD1);
  assign wr_pl2   = io_wr & (io_addr == OFF_PRELOAD2);
  assign wr_duty1 = io_wr & (io_addr == OFF_DUTY1);
  assign wr_duty2 = io_wr & (io_addr == OFF_DUTY2);
  assign wr_clk32 = io_wr & (io_addr == OFF_CLK32_CFG);
  assign wr_wen   = io_wr & (io_addr == OFF_WAKE_EN);
  assign wr_sen   = io_wr & (io_addr == OFF_SMGT_EN);
  assign wr_wsts  = io_wr & (io_addr == OFF_WAKE_STS);
  assign wr_ssts  = io_wr & (io_addr == OFF_SMGT_STS);

  // Restart from the byte being written; the stored copy only lands at this edge
  assign pl1_val = wr_pl1 ? io_wdata[CNT_W-1:0] : preload1_q;
  assign pl2_val = wr_pl2 ? io_wdata[CNT_W-1:0] : preload2_q;

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      fan_divisor_clock_control_q <= FAN_CTRL_RST;
    end else if (wr_fc) begin
      fan_divisor_clock_control_q <= io_wdata;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      duty1_q <= DUTY_RST;
    end else if (wr_duty1) begin
      duty1_q <= io_wdata;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      duty2_q <= DUTY_RST;
    end else if (wr_duty2) begin
      duty2_q <= io_wdata;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      preload1_q <= CNT_W'(PRELOAD_RST);
    end else if (wr_pl1) begin
      preload1_q <= io_wdata[CNT_W-1:0];
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      preload2_q <= CNT_W'(PRELOAD_RST);
    end else if (wr_pl2) begin
      preload2_q <= io_wdata[CNT_W-1:0];
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      clock32_config_reg_q <= CLK32_CFG_RST;
    end else if (wr_clk32) begin
      clock32_config_reg_q <= {7'h00, io_wdata[CLK32_SEL_BIT]};
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      wake_enable_reg_1_q <= EVT_RST;
    end else if (wr_wen) begin
      wake_enable_reg_1_q <= io_wdata[1:0];
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      sysmgmt_enable_reg_5_q <= EVT_RST;
    end else if (wr_sen) begin
      sysmgmt_enable_reg_5_q <= io_wdata[1:0];
    end
  end

  ftm_tach_chan #(
    .CNT_W          (CNT_W)
  ) u_tach1 (
    .core_clk       (core_clk),
    .rst_n          (rst_n),
    .count_tick     (count_tick),
    .tach_rise      (rise_q[0]),
    .preload_wr     (wr_pl1),
    .preload        (pl1_val),
    .div_sel        (fan_divisor_clock_control_q[FC_DIV1_LSB +: 2]),
    .count_q        (count1),
    .thresh_pulse_q (thr1)
  );

  ftm_tach_chan #(
    .CNT_W          (CNT_W)
  ) u_tach2 (
    .core_clk       (core_clk),
    .rst_n          (rst_n),
    .count_tick     (count_tick),
    .tach_rise      (rise_q[1]),
    .preload_wr     (wr_pl2),
    .preload        (pl2_val),
    .div_sel        (fan_divisor_clock_control_q[FC_DIV2_LSB +: 2]),
    .count_q        (count2),
    .thresh_pulse_q (thr2)
  );

  assign evt_set[EVT_FAN1_BIT] = thr1;
  assign evt_set[EVT_FAN2_BIT] = thr2;

  // Write one to clear; a new event in the same cycle wins
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      wake_sts_q <= EVT_RST;
    end else if (wr_wsts) begin
      wake_sts_q <= (wake_sts_q & ~io_wdata[1:0]) | evt_set;
    end else begin
      wake_sts_q <= wake_sts_q | evt_set;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      smgt_sts_q <= EVT_RST;
    end else if (wr_ssts) begin
      smgt_sts_q <= (smgt_sts_q & ~io_wdata[1:0]) | evt_set;
    end else begin
      smgt_sts_q <= smgt_sts_q | evt_set;
    end
  end

  assign wake_event    = |(wake_sts_q & wake_enable_reg_1_q);
  assign sysmgmt_event = |(smgt_sts_q & sysmgmt_enable_reg_5_q);

  ftm_pwm_tick u_pwm1 (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .src_sel  (fan_divisor_clock_control_q[FC_SRC1_BIT]),
    .clk_sel  (duty1_q[DUTY_CSEL_BIT]),
    .mult     (fan_divisor_clock_control_q[FC_MUL1_BIT]),
    .step_q   (fan1_pwm_step)
  );

  ftm_pwm_tick u_pwm2 (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .src_sel  (fan_divisor_clock_control_q[FC_SRC2_BIT]),
    .clk_sel  (duty2_q[DUTY_CSEL_BIT]),
    .mult     (fan_divisor_clock_control_q[FC_MUL2_BIT]),
    .step_q   (fan2_pwm_step)
  );

  // Unmapped offsets read as zero
  always_comb begin
    rd_mux = 8'h00;
    case (io_addr)
      OFF_WAKE_STS:  rd_mux = {6'h00, wake_sts_q};
      OFF_WAKE_EN:   rd_mux = {6'h00, wake_enable_reg_1_q};
      OFF_SMGT_STS:  rd_mux = {6'h00, smgt_sts_q};
      OFF_SMGT_EN:   rd_mux = {6'h00, sysmgmt_enable_reg_5_q};
      OFF_CLK32_CFG: rd_mux = clock32_config_reg_q;
      OFF_DUTY1:     rd_mux = duty1_q;
      OFF_DUTY2:     rd_mux = duty2_q;
      OFF_FAN_CTRL:  rd_mux = fan_divisor_clock_control_q;
      OFF_PRELOAD1:  rd_mux = 8'(preload1_q);
      OFF_PRELOAD2:  rd_mux = 8'(preload2_q);
      OFF_COUNT1:    rd_mux = 8'(count1);
      OFF_COUNT2:    rd_mux = 8'(count2);
      default:       rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      io_rdata_q <= 8'h00;
    end else if (io_rd) begin
      io_rdata_q <= rd_mux;
    end
  end
endmodule // ftm_fan_tach_monitor

/* sim/ftm_fan_model.sv */
`timescale 1ns/1ns
module ftm_fan_model #(
  parameter int unsigned HALF_NS = 1_000_000
) (
  input  wire logic run,
  output logic      tach
);
  // Two tach pulses per turn; a stopped fan parks its output low
  always begin
    tach = 1'b0;
    @(posedge run);
    while (run === 1'b1) begin
      tach = 1'b1;
      #(HALF_NS);
      tach = 1'b0;
      #(HALF_NS);
    end
  end
endmodule // ftm_fan_model

/* sim/ftm_chk_asserts.sv */
`timescale 1ns/1ns
module ftm_chk
  import ftm_pkg::*;
#(
  parameter int unsigned CNT_W = 8
) (
  input wire logic       core_clk,
  input wire logic       rst_n,
  input wire logic [7:0] io_addr,
  input wire logic       io_wr,
  input wire logic       io_rd,
  input wire logic [7:0] io_wdata,
  input wire logic [7:0] io_rdata_q,
  input wire logic       wake_event,
  input wire logic       sysmgmt_event,
  input wire logic       fan1_pwm_step
);
  logic [7:0]  fc_q, pre_q;
  logic [1:0]  wen_q, sen_q, stale_q;
  logic        clk_q, csel_q;
  logic [11:0] gap_q, step_div;
  assign step_div = 12'((fc_q[FC_SRC1_BIT] ? (csel_q ? PWM_DIV11 : PWM_DIV10)
                         : (csel_q ? PWM_DIV01 : PWM_DIV00)) >> fc_q[FC_MUL1_BIT]);
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      fc_q   <= FAN_CTRL_RST;
      pre_q  <= PRELOAD_RST;
      wen_q  <= EVT_RST;
      sen_q  <= EVT_RST;
      clk_q  <= 1'b0;
      csel_q <= 1'b0;
    end else if (io_wr) begin
      case (io_addr)
        OFF_FAN_CTRL:  fc_q <= io_wdata;
        OFF_PRELOAD1:  pre_q <= io_wdata;
        OFF_WAKE_EN:   wen_q <= io_wdata[1:0];
        OFF_SMGT_EN:   sen_q <= io_wdata[1:0];
        OFF_CLK32_CFG: clk_q <= io_wdata[CLK32_SEL_BIT];
        OFF_DUTY1:     csel_q <= io_wdata[DUTY_CSEL_BIT];
        default: ;
      endcase
    end
  end
  // Two steps after a rate write go untimed, the divider may be mid-count
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      gap_q   <= 12'h000;
      stale_q <= 2'h2;
    end else begin
      gap_q <= fan1_pwm_step ? 12'h000 : gap_q + 12'h001;
      if (io_wr && (io_addr == OFF_FAN_CTRL || io_addr == OFF_DUTY1)) begin
        stale_q <= 2'h2;
      end else if (fan1_pwm_step && stale_q != 2'h0) begin
        stale_q <= stale_q - 2'h1;
      end
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  property p_fc_rd; io_rd && io_addr == OFF_FAN_CTRL |=> io_rdata_q == $past(fc_q); endproperty
  a_fc_rd: assert property (p_fc_rd) else $error("fan control read mismatch");
  property p_pre_rd; io_rd && io_addr == OFF_PRELOAD1 |=> io_rdata_q == $past(pre_q); endproperty
  a_pre_rd: assert property (p_pre_rd) else $error("preload read mismatch");
  property p_wen_rd; io_rd && io_addr == OFF_WAKE_EN ##1 1'b1 |->
    io_rdata_q[1:0] == $past(wen_q); endproperty
  a_wen_rd: assert property (p_wen_rd) else $error("wake enable read mismatch");
  property p_sen_rd; io_rd && io_addr == OFF_SMGT_EN |=>
    io_rdata_q[1:0] == $past(sen_q); endproperty
  a_sen_rd: assert property (p_sen_rd) else $error("sysmgmt enable read mismatch");
  property p_clk_rd; io_rd && io_addr == OFF_CLK32_CFG |=>
    io_rdata_q[0] == $past(clk_q); endproperty
  a_clk_rd: assert property (p_clk_rd) else $error("clock select read mismatch");
  property p_wake_off; wen_q == 2'h0 |-> !wake_event; endproperty
  a_wake_off: assert property (p_wake_off) else $error("wake event while disabled");
  property p_smgt_off; sysmgmt_event |-> sen_q != 2'h0; endproperty
  a_smgt_off: assert property (p_smgt_off) else $error("sysmgmt event while masked");
  property p_pwm_gap; fan1_pwm_step && stale_q == 2'h0 |-> gap_q == step_div - 12'h001; endproperty
  a_pwm_gap: assert property (p_pwm_gap) else $error("pwm step spacing wrong");
  c_wake: cover property ($rose(wake_event));
  c_smgt: cover property ($rose(sysmgmt_event));
  c_slow: cover property (fan1_pwm_step && stale_q == 2'h0 && fc_q[FC_SRC1_BIT]);
endmodule // ftm_chk
bind ftm_fan_tach_monitor ftm_chk #(.CNT_W(CNT_W)) u_chk (.core_clk(core_clk), .rst_n(rst_n),
  .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata), .io_rdata_q(io_rdata_q),
  .wake_event(wake_event), .sysmgmt_event(sysmgmt_event), .fan1_pwm_step(fan1_pwm_step));

/* sim/testbench.sv */
`timescale 1ns/1ns
module testbench;
  import ftm_pkg::*;
  logic       core_clk, tach1, tach2, wake_event, sysmgmt_event, step1, step2;
  logic       rst_n = 1'b0, run1 = 1'b0, run2 = 1'b0, ext_on = 1'b0, ext_pin = 1'b0;
  logic       io_wr = 1'b0, io_rd = 1'b0;
  logic [7:0] io_addr = 8'h00, io_wdata = 8'h00, io_rdata_q, rv;
  int         n_mismatch = 0, check_count = 0, g, e;
  int         base[4] = '{10, 6, 3906, 2604};
  ftm_fan_tach_monitor #(.CNT_W(8)) dut (.core_clk(core_clk), .rst_n(rst_n),
    .tach_input_one(tach1), .tach_input_two(tach2), .ext_32k_clock_pin(ext_pin),
    .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata),
    .io_rdata_q(io_rdata_q), .wake_event(wake_event), .sysmgmt_event(sysmgmt_event),
    .fan1_pwm_step(step1), .fan2_pwm_step(step2));
  ftm_fan_model fan1 (.run(run1), .tach(tach1));
  ftm_fan_model fan2 (.run(run2), .tach(tach2));
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  // Fast stand-in for the 32 kHz pin, 20 core cycles a period, keeps runs short
  always @(negedge core_clk) begin
    repeat (9) @(negedge core_clk);
    if (ext_on) ext_pin <= ~ext_pin;
  end
  task automatic chk(input string nm, input logic [15:0] lo, input logic [15:0] hi,
                     input logic [15:0] s);
    check_count++;
    if ($isunknown(s) || s < lo || s > hi) begin
      n_mismatch++;
      $display("wrong value %s expected %h..%h seen %h", nm, lo, hi, s);
    end
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // Watched output: 0 wake event, 1 fan1 step, 2 fan2 step
  task automatic wait_hi(input int sel, output int n);
    logic s;
    n = 0;
    do begin
      @(negedge core_clk);
      n++;
      if (n > 9000) begin
        n_mismatch++;
        $display("wrong value wait expected 1 seen timeout");
        summarize;
      end
      s = (sel == 0) ? wake_event : ((sel == 1) ? step1 : step2);
    end while (s !== 1'b1);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge core_clk);
    io_addr = a;
    io_wdata = d;
    io_wr = 1'b1;
    @(negedge core_clk);
    io_wr = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(negedge core_clk);
    io_addr = a;
    io_rd = 1'b1;
    @(negedge core_clk);
    io_rd = 1'b0;
    rv = io_rdata_q;
  endtask
  task automatic t_regs;
    rd(OFF_FAN_CTRL);
    chk("fan ctrl reset", 8'h50, 8'h50, rv);
    rd(OFF_PRELOAD1);
    chk("preload reset", 0, 0, rv);
    rd(8'h55);
    chk("unmapped", 0, 0, rv);
    for (int n = 0; n < 4; n++) begin
      wr(OFF_FAN_CTRL, {n[1:0], n[1:0], 4'hA});
      rd(OFF_FAN_CTRL);
      chk("fan ctrl rw", {n[1:0], n[1:0], 4'hA}, {n[1:0], n[1:0], 4'hA}, rv);
    end
    $display("done regs");
  endtask
  task automatic t_rate;
    for (int n = 0; n < 4; n++) begin
      wr(OFF_FAN_CTRL, {n[1:0], 6'h10});
      wr(OFF_PRELOAD1, 8'h00);
      repeat ((INT_32K_DIV * 4) << n) @(negedge core_clk);
      rd(OFF_COUNT1);
      chk("count rate", 3, 5, rv);
    end
    $display("done rate");
  endtask
  task automatic t_tach;
    wr(OFF_FAN_CTRL, 8'h00);
    wr(OFF_PRELOAD1, 8'h20);
    wr(OFF_PRELOAD2, 8'h20);
    repeat (2000) @(negedge core_clk);
    run1 = 1'b1;
    run2 = 1'b1;
    repeat (20) @(negedge core_clk);
    run1 = 1'b0;
    run2 = 1'b0;
    rd(OFF_COUNT1);
    chk("fan1 restart", 8'h20, 8'h21, rv);
    rd(OFF_COUNT2);
    chk("fan2 restart", 8'h20, 8'h21, rv);
    wr(OFF_PRELOAD1, 8'hF0);
    repeat (5400) @(negedge core_clk);
    rd(OFF_COUNT1);
    chk("saturate", 8'hFF, 8'hFF, rv);
    repeat (700) @(negedge core_clk);
    rd(OFF_COUNT1);
    chk("stay saturated", 8'hFF, 8'hFF, rv);
    $display("done tach");
  endtask
  task automatic t_event;
    wr(OFF_PRELOAD1, 8'hBE);
    repeat (5) @(negedge core_clk);
    wr(OFF_WAKE_STS, 8'h03);
    wr(OFF_SMGT_STS, 8'h03);
    wr(OFF_WAKE_EN, 8'h01);
    wr(OFF_PRELOAD1, 8'hBE);
    rd(OFF_WAKE_EN);
    rd(OFF_SMGT_EN);
    chk("wake early", 0, 0, wake_event);
    wait_hi(0, g);
    chk("wake delay", 300, 700, 16'(g));
    chk("smgt disabled", 0, 0, sysmgmt_event);
    wr(OFF_SMGT_EN, 8'h01);
    chk("smgt held", 1, 1, sysmgmt_event);
    wr(OFF_WAKE_STS, 8'h01);
    chk("wake cleared", 0, 0, wake_event);
    wr(OFF_SMGT_EN, 8'h00);
    chk("smgt masked", 0, 0, sysmgmt_event);
    $display("done event");
  endtask
  task automatic t_ext;
    wr(OFF_CLK32_CFG, 8'h01);
    ext_on = 1'b1;
    wr(OFF_PRELOAD1, 8'h00);
    repeat (400) @(negedge core_clk);
    rd(OFF_COUNT1);
    chk("ext count", 19, 21, rv);
    ext_on = 1'b0;
    rd(OFF_CLK32_CFG);
    wr(OFF_CLK32_CFG, 8'h00);
    $display("done ext");
  endtask
  task automatic t_pwm;
    for (int c = 0; c < 8; c++) begin
      wr(OFF_DUTY1, {c[1], 7'h00});
      wr(OFF_DUTY2, {c[1], 7'h00});
      wr(OFF_FAN_CTRL, {4'h5, c[2], c[2], c[0], c[0]});
      e = base[{c[0], c[1]}] >> c[2];
      repeat (3) wait_hi(1, g);
      chk("pwm1 gap", 16'(e), 16'(e), 16'(g));
      repeat (2) wait_hi(2, g);
      chk("pwm2 gap", 16'(e), 16'(e), 16'(g));
    end
    $display("done pwm");
  endtask
  initial begin
    repeat (8) @(negedge core_clk);
    rst_n = 1'b1;
    t_regs;
    t_rate;
    t_tach;
    t_event;
    t_ext;
    t_pwm;
    summarize;
  end
endmodule // testbench
